// ===== include/mcu_pkg.sv
// Purpose: Shared constants and types for the instruction decode and timing block.
// Assumes: Single system clock; cycle counts are whole system clock cycles.
// Notes:   Opcode classes carry no codes; the decoder picks them from the opcode.
package mcu_pkg;
	// Instruction lengths in bytes.
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	// Execution times in system clock cycles.
	localparam logic [3:0] CYC_1 = 4'h1;
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_3 = 4'h3;
	localparam logic [3:0] CYC_4 = 4'h4;
	localparam logic [3:0] CYC_5 = 4'h5;
	localparam logic [3:0] CYC_6 = 4'h6;
	localparam logic [3:0] CYC_8 = 4'h8;
	// Stack pointer value after reset.
	localparam logic [7:0] STACK_RESET = 8'h07;
	// Direct addresses from here upward select special function registers.
	localparam logic [7:0] SPECIAL_BASE = 8'h80;
	// Lowest program counter bit kept by a page target.
	localparam int PAGE_LSB = 11;
	// Spare opcode that runs as a no-operation.
	localparam logic [7:0] OP_SPARE = 8'hA5;
	typedef enum logic [4:0] {
		CL_PLAIN, CL_PG_JUMP, CL_PG_CALL, CL_FAR_JUMP, CL_FAR_CALL, CL_REL_JUMP, CL_JMP_IND,
		CL_JC, CL_JNC, CL_JZ, CL_JNZ, CL_DEC_JUMP, CL_JB, CL_JNB, CL_JB_CLR,
		CL_CMP_AD, CL_CMP_AI, CL_CMP_OP, CL_TBL_DP, CL_TBL_PC,
		CL_EXT_RI_RD, CL_EXT_RI_WR, CL_EXT_DP_RD, CL_EXT_DP_WR,
		CL_LOAD_DP, CL_PUSH, CL_POP, CL_NIB_XCH, CL_RET
	} mcu_class_t;
	typedef enum logic {
		ST_READY,
		ST_EXEC
	} mcu_state_t;
endpackage : mcu_pkg

// ===== hw/mcu_op_decode.sv
// Purpose: Opcode to class, byte length and not-taken / taken cycle counts.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Groups follow the low opcode nibble, with bank register and pointer forms first.
`timescale 1ns/100ps
`default_nettype none
module mcu_op_decode
	import mcu_pkg::*;
(
	// Opcode
	input  wire logic [7:0] opcode_in,
	// Decode results
	output logic       [1:0] len_out,
	output logic       [3:0] cyc_nt_out,
	output logic       [3:0] cyc_tk_out,
	output var mcu_class_t   cls_out
);
	always_comb begin
		len_out    = LEN_1;
		cyc_nt_out = CYC_1;
		cyc_tk_out = CYC_1;
		cls_out    = CL_PLAIN;
		if (opcode_in[3]) begin
			unique case (opcode_in[7:4])
				4'h7, 4'h8, 4'hA: begin
					len_out = LEN_2; cyc_nt_out = CYC_2; cyc_tk_out = CYC_2;
				end
				4'hB: begin
					len_out = LEN_3; cyc_nt_out = CYC_3; cyc_tk_out = CYC_5; cls_out = CL_CMP_OP;
				end
				4'hD: begin
					len_out = LEN_2; cyc_nt_out = CYC_2; cyc_tk_out = CYC_4; cls_out = CL_DEC_JUMP;
				end
				4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hC, 4'hE, 4'hF: ;
			endcase
		end else if (opcode_in[2:1] == 2'b11) begin
			cyc_nt_out = CYC_2;
			cyc_tk_out = CYC_2;
			unique case (opcode_in[7:4])
				4'h7, 4'h8, 4'hA: len_out = LEN_2;
				4'hB: begin
					len_out = LEN_3; cyc_nt_out = CYC_4; cyc_tk_out = CYC_6; cls_out = CL_CMP_OP;
				end
				4'hD: cls_out = CL_NIB_XCH;
				4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hC, 4'hE, 4'hF: ;
			endcase
		end else begin
			unique case (opcode_in[3:0])
				4'h0: begin
					unique case (opcode_in[7:4])
						4'h0: ;
						4'h1, 4'h2, 4'h3: begin
							len_out = LEN_3; cyc_nt_out = CYC_3; cyc_tk_out = CYC_5;
							cls_out = (opcode_in[5:4] == 2'b01) ? CL_JB_CLR :
								(opcode_in[5:4] == 2'b10) ? CL_JB : CL_JNB;
						end
						4'h4, 4'h5, 4'h6, 4'h7: begin
							len_out = LEN_2; cyc_nt_out = CYC_2; cyc_tk_out = CYC_4;
							cls_out = (opcode_in[5:4] == 2'b00) ? CL_JC :
								(opcode_in[5:4] == 2'b01) ? CL_JNC :
								(opcode_in[5:4] == 2'b10) ? CL_JZ : CL_JNZ;
						end
						4'h8: begin
							len_out = LEN_2; cyc_nt_out = CYC_4; cyc_tk_out = CYC_4; cls_out = CL_REL_JUMP;
						end
						4'h9: begin
							len_out = LEN_3; cyc_nt_out = CYC_3; cyc_tk_out = CYC_3; cls_out = CL_LOAD_DP;
						end
						4'hA, 4'hB, 4'hC, 4'hD: begin
							len_out = LEN_2; cyc_nt_out = CYC_2; cyc_tk_out = CYC_2;
							cls_out = (opcode_in[7:4] == 4'hC) ? CL_PUSH :
								(opcode_in[7:4] == 4'hD) ? CL_POP : CL_PLAIN;
						end
						4'hE, 4'hF: begin
							cyc_nt_out = CYC_3; cyc_tk_out = CYC_3;
							cls_out = opcode_in[4] ? CL_EXT_DP_WR : CL_EXT_DP_RD;
						end
					endcase
				end
				4'h1: begin
					len_out = LEN_2; cyc_nt_out = CYC_4; cyc_tk_out = CYC_4;
					cls_out = opcode_in[4] ? CL_PG_CALL : CL_PG_JUMP;
				end
				4'h2, 4'h3: begin
					unique case (opcode_in[7:4])
						4'h0, 4'h1: begin
							if (opcode_in[0]) begin
								cls_out = CL_PLAIN;
							end else begin
								len_out = LEN_3; cyc_nt_out = CYC_5; cyc_tk_out = CYC_5;
								cls_out = opcode_in[4] ? CL_FAR_CALL : CL_FAR_JUMP;
							end
						end
						4'h2, 4'h3: begin
							if (!opcode_in[0]) begin
								cyc_nt_out = CYC_6; cyc_tk_out = CYC_6; cls_out = CL_RET;
							end
						end
						4'h4, 4'h5, 4'h6: begin
							len_out    = opcode_in[0] ? LEN_3 : LEN_2;
							cyc_nt_out = opcode_in[0] ? CYC_3 : CYC_2;
							cyc_tk_out = cyc_nt_out;
						end
						4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: begin
							if (opcode_in[0]) begin
								// Carry-only and accumulator forms, table reads, indirect jump.
								unique case (opcode_in[7:4])
									4'h7: begin
										cyc_nt_out = CYC_4; cyc_tk_out = CYC_4; cls_out = CL_JMP_IND;
									end
									4'h8, 4'h9: begin
										cyc_nt_out = CYC_3; cyc_tk_out = CYC_3;
										cls_out = opcode_in[4] ? CL_TBL_DP : CL_TBL_PC;
									end
									4'hA, 4'hB, 4'hC, 4'hD: ;
								endcase
							end else begin
								len_out = LEN_2; cyc_nt_out = CYC_2; cyc_tk_out = CYC_2;
							end
						end
						4'hE, 4'hF: begin
							cyc_nt_out = CYC_3; cyc_tk_out = CYC_3;
							cls_out = opcode_in[4] ? CL_EXT_RI_WR : CL_EXT_RI_RD;
						end
					endcase
				end
				4'h4: begin
					unique case (opcode_in[7:4])
						4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: begin
							len_out = LEN_2; cyc_nt_out = CYC_2; cyc_tk_out = CYC_2;
						end
						4'h8: begin
							cyc_nt_out = CYC_8; cyc_tk_out = CYC_8;
						end
						4'hA: begin
							cyc_nt_out = CYC_4; cyc_tk_out = CYC_4;
						end
						4'hB: begin
							len_out = LEN_3; cyc_nt_out = CYC_3; cyc_tk_out = CYC_5; cls_out = CL_CMP_AI;
						end
						4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: ;
					endcase
				end
				4'h5: begin
					len_out = LEN_2; cyc_nt_out = CYC_2; cyc_tk_out = CYC_2;
					unique case (opcode_in[7:4])
						4'h7, 4'h8: begin
							len_out = LEN_3; cyc_nt_out = CYC_3; cyc_tk_out = CYC_3;
						end
						4'hA: begin
							len_out = LEN_1; cyc_nt_out = CYC_1; cyc_tk_out = CYC_1;
						end
						4'hB, 4'hD: begin
							len_out = LEN_3; cyc_nt_out = CYC_3; cyc_tk_out = CYC_5;
							cls_out = opcode_in[6] ? CL_DEC_JUMP : CL_CMP_AD;
						end
						4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hC, 4'hE, 4'hF: ;
					endcase
				end
				default: ;
			endcase
		end
	end
endmodule : mcu_op_decode
`default_nettype wire

// ===== hw/mcu_instruction_timing.sv
// Purpose: Decode one issued instruction, time it to the cycle and produce its effects.
// Assumes: The core issues only while ready_out is high; inputs are synchronous.
// Notes:   Decode results are held from the issue edge until the next issue.
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_timing
	import mcu_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// Instruction issue
	input  wire logic        issue_in,
	input  wire logic [7:0]  opcode_in,
	input  wire logic [7:0]  op1_in,
	input  wire logic [7:0]  op2_in,
	input  wire logic [15:0] pc_in,
	// Core state
	input  wire logic [7:0]  acc_in,
	input  wire logic        carry_in,
	input  wire logic        bit_value_in,
	input  wire logic [7:0]  operand_in,
	input  wire logic [15:0] data_pointer_in,
	input  wire logic [1:0]  bank_select_field_in,
	input  wire logic [7:0]  code_byte_in,
	// Sequencing
	output logic             ready_out,
	output logic             done_out,
	// Decode results
	output logic [1:0]       length_out,
	output logic [3:0]       cycles_out,
	output logic             taken_out,
	output logic [15:0]      new_pc_out,
	// Operand addressing
	output logic [7:0]       bank_reg_addr_out,
	output logic [7:0]       pointer_reg_addr_out,
	output logic             op1_is_special_out,
	output logic             op2_is_special_out,
	// Stack
	output logic [7:0]       stack_pointer_out,
	output logic [7:0]       stack_addr_out,
	output logic             stack_wr_out,
	// Memory side effects
	output logic [15:0]      code_addr_out,
	output logic [15:0]      ext_addr_out,
	output logic             ext_rd_out,
	output logic             ext_wr_out,
	output logic             bit_clear_out,
	output logic             acc_wr_out,
	output logic [7:0]       acc_data_out,
	output logic             mem_wr_out,
	output logic [7:0]       mem_data_out
);
	logic [1:0]  dec_len;
	logic [3:0]  dec_nt;
	logic [3:0]  dec_tk;
	mcu_class_t  dec_cls;
	logic        accept;
	logic [15:0] next_pc;
	logic [7:0]  rel_byte;
	logic [15:0] rel_target;
	logic [15:0] page_target;
	logic [15:0] full_target;
	logic [15:0] branch_target;
	logic [4:0]  page_now;
	logic [7:0]  dec_value;
	logic        cond_taken;
	logic        jump_uncond;
	logic        take;
	logic [3:0]  cycles_nxt;
	logic        finishing;
	mcu_state_t  state_r;
	logic [3:0]  remain_r;
	logic        table_pend_r;
	logic        nib_pend_r;
	logic [7:0]  nib_acc_r;
	logic [7:0]  nib_mem_r;

	mcu_op_decode u_decode (
		.opcode_in  (opcode_in),
		.len_out    (dec_len),
		.cyc_nt_out (dec_nt),
		.cyc_tk_out (dec_tk),
		.cls_out    (dec_cls)
	);

	assign accept      = issue_in && ready_out;
	assign next_pc     = pc_in + {14'h0000, dec_len};
	assign rel_byte    = (dec_len == LEN_3) ? op2_in : op1_in;
	assign rel_target  = next_pc + {{8{rel_byte[7]}}, rel_byte};
	assign page_target = {next_pc[15:PAGE_LSB], opcode_in[7:5], op1_in};
	assign full_target = {op1_in, op2_in};
	assign page_now    = next_pc[15:PAGE_LSB];
	assign dec_value   = operand_in - 8'h01;
	assign finishing   = (state_r == ST_EXEC) && (remain_r == CYC_1);

	// Branch condition and destination.
	always_comb begin
		cond_taken    = 1'b0;
		jump_uncond   = 1'b0;
		branch_target = rel_target;
		unique case (dec_cls)
			CL_JC:         cond_taken = carry_in;
			CL_JNC:        cond_taken = !carry_in;
			CL_JZ:         cond_taken = (acc_in == 8'h00);
			CL_JNZ:        cond_taken = (acc_in != 8'h00);
			CL_JB, CL_JB_CLR: cond_taken = bit_value_in;
			CL_JNB:        cond_taken = !bit_value_in;
			CL_CMP_AD:     cond_taken = (acc_in != operand_in);
			CL_CMP_AI:     cond_taken = (acc_in != op1_in);
			CL_CMP_OP:     cond_taken = (operand_in != op1_in);
			CL_DEC_JUMP:   cond_taken = (dec_value != 8'h00);
			CL_REL_JUMP:   jump_uncond = 1'b1;
			CL_PG_JUMP, CL_PG_CALL: begin
				jump_uncond   = 1'b1;
				branch_target = page_target;
			end
			CL_FAR_JUMP, CL_FAR_CALL: begin
				jump_uncond   = 1'b1;
				branch_target = full_target;
			end
			CL_JMP_IND: begin
				jump_uncond   = 1'b1;
				branch_target = data_pointer_in + {8'h00, acc_in};
			end
			default: ;
		endcase
		take       = cond_taken || jump_uncond;
		cycles_nxt = take ? dec_tk : dec_nt;
	end

	// Cycle sequencer: ready and done rise together in the last cycle.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r   <= ST_READY;
			remain_r  <= 4'h0;
			ready_out <= 1'b1;
			done_out  <= 1'b0;
		end else if (accept) begin
			remain_r  <= cycles_nxt - CYC_1;
			ready_out <= (cycles_nxt == CYC_1);
			done_out  <= (cycles_nxt == CYC_1);
			state_r   <= (cycles_nxt == CYC_1) ? ST_READY : ST_EXEC;
		end else begin
			unique case (state_r)
				ST_READY: done_out <= 1'b0;
				ST_EXEC: begin
					remain_r  <= remain_r - CYC_1;
					ready_out <= finishing;
					done_out  <= finishing;
					if (finishing) begin
						state_r <= ST_READY;
					end
				end
			endcase
		end
	end

	// Decode results held for the life of the instruction.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			length_out           <= 2'h0;
			cycles_out           <= 4'h0;
			taken_out            <= 1'b0;
			new_pc_out           <= 16'h0000;
			bank_reg_addr_out    <= 8'h00;
			pointer_reg_addr_out <= 8'h00;
			op1_is_special_out   <= 1'b0;
			op2_is_special_out   <= 1'b0;
			code_addr_out        <= 16'h0000;
			ext_addr_out         <= 16'h0000;
		end else if (accept) begin
			length_out           <= dec_len;
			cycles_out           <= cycles_nxt;
			taken_out            <= take;
			new_pc_out           <= take ? branch_target : next_pc;
			bank_reg_addr_out    <= {3'b000, bank_select_field_in, opcode_in[2:0]};
			pointer_reg_addr_out <= {3'b000, bank_select_field_in, 2'b00, opcode_in[0]};
			op1_is_special_out   <= (op1_in >= SPECIAL_BASE);
			op2_is_special_out   <= (op2_in >= SPECIAL_BASE);
			code_addr_out        <= ((dec_cls == CL_TBL_PC) ? next_pc : data_pointer_in) +
				{8'h00, acc_in};
			ext_addr_out         <= (dec_cls == CL_EXT_RI_RD || dec_cls == CL_EXT_RI_WR) ?
				{8'h00, operand_in} : data_pointer_in;
		end
	end

	// Stack pointer; a push or call stores at the already incremented address.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stack_pointer_out <= STACK_RESET;
			stack_addr_out    <= 8'h00;
			stack_wr_out      <= 1'b0;
		end else begin
			stack_wr_out <= 1'b0;
			if (accept) begin
				unique case (dec_cls)
					CL_PUSH, CL_PG_CALL, CL_FAR_CALL: begin
						stack_addr_out    <= stack_pointer_out + 8'h01;
						stack_pointer_out <= stack_pointer_out +
							((dec_cls == CL_PUSH) ? 8'h01 : 8'h02);
						stack_wr_out      <= 1'b1;
					end
					CL_POP, CL_RET: begin
						stack_addr_out    <= stack_pointer_out;
						stack_pointer_out <= stack_pointer_out -
							((dec_cls == CL_POP) ? 8'h01 : 8'h02);
					end
					default: ;
				endcase
			end
		end
	end

	// Side-effect strobes; accumulator and memory writes land in the last cycle.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bit_clear_out <= 1'b0;
			ext_rd_out    <= 1'b0;
			ext_wr_out    <= 1'b0;
			table_pend_r  <= 1'b0;
			nib_pend_r    <= 1'b0;
			nib_acc_r     <= 8'h00;
			nib_mem_r     <= 8'h00;
			acc_wr_out    <= 1'b0;
			acc_data_out  <= 8'h00;
			mem_wr_out    <= 1'b0;
			mem_data_out  <= 8'h00;
		end else begin
			bit_clear_out <= accept && (dec_cls == CL_JB_CLR) && bit_value_in;
			ext_rd_out    <= accept && (dec_cls == CL_EXT_RI_RD || dec_cls == CL_EXT_DP_RD);
			ext_wr_out    <= accept && (dec_cls == CL_EXT_RI_WR || dec_cls == CL_EXT_DP_WR);
			acc_wr_out    <= finishing && (table_pend_r || nib_pend_r);
			mem_wr_out    <= finishing && nib_pend_r;
			if (accept) begin
				table_pend_r <= (dec_cls == CL_TBL_DP || dec_cls == CL_TBL_PC);
				nib_pend_r   <= (dec_cls == CL_NIB_XCH);
				nib_acc_r    <= {acc_in[7:4], operand_in[3:0]};
				nib_mem_r    <= {operand_in[7:4], acc_in[3:0]};
			end
			if (finishing) begin
				acc_data_out <= table_pend_r ? code_byte_in : nib_acc_r;
				mem_data_out <= nib_mem_r;
			end
		end
	end

	property p_ext_cycles;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && (dec_cls inside {CL_EXT_RI_RD, CL_EXT_RI_WR, CL_EXT_DP_RD, CL_EXT_DP_WR})
		|=> (!done_out && length_out == LEN_1)[*2] ##1 done_out;
	endproperty
	a_ext_cycles: assert property (p_ext_cycles) else $error("external move timing wrong");

	property p_code_read;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && (dec_cls inside {CL_TBL_DP, CL_TBL_PC})
		|=> !done_out[*2] ##1 (done_out && acc_wr_out && acc_data_out == $past(code_byte_in));
	endproperty
	a_code_read: assert property (p_code_read) else $error("code table read wrong");

	property p_dp_load;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && dec_cls == CL_LOAD_DP |=> (length_out == LEN_3 && !ready_out)[*2] ##1 done_out;
	endproperty
	a_dp_load: assert property (p_dp_load) else $error("pointer load timing wrong");

	property p_short_branch;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && dec_len == LEN_2 && (dec_cls inside {CL_JC, CL_JNC, CL_JZ, CL_JNZ, CL_DEC_JUMP})
		|=> if (taken_out) (!done_out[*3] ##1 done_out) else (!done_out ##1 done_out);
	endproperty
	a_short_branch: assert property (p_short_branch) else $error("short branch timing wrong");

	property p_bit_taken;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && take && (dec_cls inside {CL_JB, CL_JNB, CL_JB_CLR, CL_CMP_AD, CL_CMP_AI})
		|=> !done_out[*4] ##1 done_out;
	endproperty
	a_bit_taken: assert property (p_bit_taken) else $error("taken bit jump timing wrong");

	property p_ind_compare;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && dec_cls == CL_CMP_OP && !opcode_in[3] && !take
		|=> !done_out[*3] ##1 done_out;
	endproperty
	a_ind_compare: assert property (p_ind_compare) else $error("indirect compare timing wrong");

	property p_page_jump;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && (dec_cls inside {CL_PG_JUMP, CL_PG_CALL})
		|=> new_pc_out[15:PAGE_LSB] == $past(page_now) && cycles_out == CYC_4;
	endproperty
	a_page_jump: assert property (p_page_jump) else $error("page target wrong");

	property p_long_jump;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && (dec_cls inside {CL_FAR_JUMP, CL_FAR_CALL})
		|=> new_pc_out == $past(full_target) && length_out == LEN_3 && cycles_out == CYC_5;
	endproperty
	a_long_jump: assert property (p_long_jump) else $error("long target wrong");

	property p_rel_jump;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && dec_cls == CL_REL_JUMP |=> new_pc_out == $past(rel_target) && cycles_out == CYC_4;
	endproperty
	a_rel_jump: assert property (p_rel_jump) else $error("relative target wrong");

	property p_spare_nop;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && opcode_in == OP_SPARE |=> done_out && ready_out && length_out == LEN_1;
	endproperty
	a_spare_nop: assert property (p_spare_nop) else $error("spare opcode not a no-operation");

	property p_push_order;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept && dec_cls == CL_PUSH
		|=> stack_wr_out && stack_addr_out == $past(stack_pointer_out) + 8'h01 &&
			stack_pointer_out == stack_addr_out;
	endproperty
	a_push_order: assert property (p_push_order) else $error("push not pre-incremented");

	property p_bit_clear;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		bit_clear_out |-> $past(accept) && $past(dec_cls) == CL_JB_CLR && $past(bit_value_in) &&
			taken_out;
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit cleared without taken jump");

	property p_bank_map;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		accept |=> bank_reg_addr_out[4:3] == $past(bank_select_field_in) &&
			bank_reg_addr_out[7:5] == 3'b000 && op1_is_special_out == ($past(op1_in) >= SPECIAL_BASE);
	endproperty
	a_bank_map: assert property (p_bank_map) else $error("bank or direct address map wrong");
endmodule : mcu_instruction_timing
`default_nettype wire

// ===== verification/test_mcu_instruction_timing.sv
// Purpose: Self-checking bench for the instruction decode and timing block.
// Assumes: Issue inputs change on the rising edge, core state inputs 1 ns after it, by non-blocking assignment.
// Notes:   Cycles are counted from the accepting edge to the done pulse.
`timescale 1ns/100ps
`default_nettype none
module test_mcu_instruction_timing;
	logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, issue_in = 1'b0;
	logic        carry_in = 1'b0, bit_value_in = 1'b0;
	logic [7:0]  opcode_in = 8'h00, op1_in = 8'h00, op2_in = 8'h00, acc_in = 8'h00;
	logic [7:0]  operand_in = 8'h00, code_byte_in = 8'h00;
	logic [15:0] pc_in = 16'h0000, data_pointer_in = 16'h0000;
	logic [1:0]  bank_select_field_in = 2'h0;
	logic        ready_out, done_out, taken_out, op1_is_special_out, op2_is_special_out;
	logic        stack_wr_out, ext_rd_out, ext_wr_out, bit_clear_out, acc_wr_out, mem_wr_out;
	logic [1:0]  length_out;
	logic [3:0]  cycles_out;
	logic [15:0] new_pc_out, code_addr_out, ext_addr_out;
	logic [7:0]  bank_reg_addr_out, pointer_reg_addr_out, stack_pointer_out;
	logic [7:0]  stack_addr_out, acc_data_out, mem_data_out;
	int          n_mismatch = 0, samples_checked = 0, cyc_cnt = 0;
	logic        wr1, clr1, erd1, ewr1, accw, memw;
	logic [7:0]  accd, memd;
	// Opcode, byte length and cycle count of operations that never branch.
	logic [15:0] tbl [$] = '{16'hE213, 16'hF213, 16'hE013, 16'hF013, 16'h8313,
		16'h9033, 16'hA511, 16'h0011, 16'hC311, 16'hD311, 16'hB311, 16'hB022,
		16'hA222, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
		16'hC411, 16'h4333, 16'h6333, 16'hE612, 16'h8533};

	mcu_instruction_timing dut_u (.*);

	always #50 clk_sys_in = ~clk_sys_in;

	task end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim

	always @(posedge clk_sys_in) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic run_op(input logic [7:0] op, o1, o2, input logic [15:0] pc,
		input logic [1:0] len, input logic [3:0] cyc, input logic tk, input logic [15:0] npc);
		int n;
		@(posedge clk_sys_in);
		issue_in <= 1'b1;
		opcode_in <= op;
		op1_in <= o1;
		op2_in <= o2;
		pc_in <= pc;
		@(posedge clk_sys_in);
		issue_in <= 1'b0;
		#1;
		wr1 = stack_wr_out;
		clr1 = bit_clear_out;
		erd1 = ext_rd_out;
		ewr1 = ext_wr_out;
		n = 1;
		while (done_out !== 1'b1 && n < 12) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		accd = acc_data_out;
		memd = mem_data_out;
		accw = acc_wr_out;
		memw = mem_wr_out;
		chk("ready", 16'h0001, 16'(ready_out));
		chk("cycles", 16'(cyc), 16'(n));
		chk("cycles_out", 16'(cyc), 16'(cycles_out));
		chk("length", 16'(len), 16'(length_out));
		chk("taken", 16'(tk), 16'(taken_out));
		chk("new_pc", npc, new_pc_out);
	endtask : run_op

	task t_stack;
		chk("stack_reset", 16'h0007, 16'(stack_pointer_out));
		run_op(8'hC0, 8'h30, 8'h00, 16'h0010, 2'h2, 4'h2, 1'b0, 16'h0012);
		chk("stack_push", 16'h0008, 16'(stack_pointer_out));
		chk("stack_addr", 16'h0008, 16'(stack_addr_out));
		chk("stack_wr", 16'h0001, 16'(wr1));
		run_op(8'hD0, 8'h30, 8'h00, 16'h0010, 2'h2, 4'h2, 1'b0, 16'h0012);
		chk("stack_pop", 16'h0007, 16'(stack_pointer_out));
	endtask : t_stack

	task t_table;
		foreach (tbl[i]) run_op(tbl[i][15:8], 8'h40, 8'h41, 16'h0400, tbl[i][5:4],
			tbl[i][3:0], 1'b0, 16'h0400 + 16'(tbl[i][5:4]));
		acc_in <= 8'h3C;
		operand_in <= 8'h96;
		code_byte_in <= 8'h5A;
		run_op(8'h93, 8'h00, 8'h00, 16'h0400, 2'h1, 4'h3, 1'b0, 16'h0401);
		chk("table_acc", 16'h005A, 16'(accd));
		chk("table_acc_wr", 16'h0001, 16'(accw));
		chk("code_addr", 16'h003C, code_addr_out);
		run_op(8'hD6, 8'h00, 8'h00, 16'h0400, 2'h1, 4'h2, 1'b0, 16'h0401);
		chk("nib_acc", 16'h0036, 16'(accd));
		chk("nib_mem", 16'h009C, 16'(memd));
		chk("nib_acc_wr", 16'h0001, 16'(accw));
		chk("nib_mem_wr", 16'h0001, 16'(memw));
		run_op(8'hE2, 8'h00, 8'h00, 16'h0400, 2'h1, 4'h3, 1'b0, 16'h0401);
		chk("ext_rd", 16'h0001, 16'(erd1));
		chk("ext_addr", 16'h0096, ext_addr_out);
		data_pointer_in <= 16'h1234;
		run_op(8'hF0, 8'h00, 8'h00, 16'h0400, 2'h1, 4'h3, 1'b0, 16'h0401);
		chk("ext_wr", 16'h0001, 16'(ewr1));
		chk("ext_addr_dp", 16'h1234, ext_addr_out);
	endtask : t_table

	task t_addr;
		bank_select_field_in <= 2'h2;
		run_op(8'hE9, 8'h00, 8'h00, 16'h0000, 2'h1, 4'h1, 1'b0, 16'h0001);
		chk("bank_reg", 16'h0011, 16'(bank_reg_addr_out));
		bank_select_field_in <= 2'h3;
		run_op(8'hE7, 8'h00, 8'h00, 16'h0000, 2'h1, 4'h2, 1'b0, 16'h0001);
		chk("pointer_reg", 16'h0019, 16'(pointer_reg_addr_out));
		run_op(8'h85, 8'h7F, 8'h80, 16'h0000, 2'h3, 4'h3, 1'b0, 16'h0003);
		chk("op1_special", 16'h0000, 16'(op1_is_special_out));
		chk("op2_special", 16'h0001, 16'(op2_is_special_out));
	endtask : t_addr

	task t_branch;
		carry_in <= 1'b0;
		acc_in <= 8'h00;
		operand_in <= 8'h01;
		run_op(8'h40, 8'hF0, 8'h00, 16'h1234, 2'h2, 4'h2, 1'b0, 16'h1236);
		run_op(8'h60, 8'h05, 8'h00, 16'h0100, 2'h2, 4'h4, 1'b1, 16'h0107);
		run_op(8'h70, 8'h05, 8'h00, 16'h0100, 2'h2, 4'h2, 1'b0, 16'h0102);
		run_op(8'hDB, 8'h7F, 8'h00, 16'h0000, 2'h2, 4'h2, 1'b0, 16'h0002);
		carry_in <= 1'b1;
		operand_in <= 8'h05;
		bit_value_in <= 1'b1;
		run_op(8'h40, 8'hF0, 8'h00, 16'h1234, 2'h2, 4'h4, 1'b1, 16'h1226);
		run_op(8'h10, 8'h20, 8'h80, 16'h0200, 2'h3, 4'h5, 1'b1, 16'h0183);
		chk("bit_clear", 16'h0001, 16'(clr1));
		run_op(8'hB6, 8'h05, 8'h02, 16'h0200, 2'h3, 4'h4, 1'b0, 16'h0203);
		run_op(8'hB6, 8'h06, 8'h02, 16'h0200, 2'h3, 4'h6, 1'b1, 16'h0205);
		run_op(8'hD5, 8'h30, 8'h01, 16'h0200, 2'h3, 4'h5, 1'b1, 16'h0204);
		bit_value_in <= 1'b0;
		run_op(8'h10, 8'h20, 8'h80, 16'h0200, 2'h3, 4'h3, 1'b0, 16'h0203);
		chk("bit_kept", 16'h0000, 16'(clr1));
		run_op(8'h01, 8'h55, 8'h00, 16'h17FF, 2'h2, 4'h4, 1'b1, 16'h1855);
		run_op(8'h11, 8'h55, 8'h00, 16'h17FF, 2'h2, 4'h4, 1'b1, 16'h1855);
		run_op(8'h02, 8'h1F, 8'hE0, 16'h0000, 2'h3, 4'h5, 1'b1, 16'h1FE0);
		run_op(8'h80, 8'hFE, 8'h00, 16'h0300, 2'h2, 4'h4, 1'b1, 16'h0300);
		acc_in <= 8'h10;
		data_pointer_in <= 16'h2000;
		run_op(8'h73, 8'h00, 8'h00, 16'h0300, 2'h1, 4'h4, 1'b1, 16'h2010);
	endtask : t_branch

	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_stack();
		t_table();
		t_addr();
		t_branch();
		end_sim();
	end
endmodule : test_mcu_instruction_timing
`default_nettype wire
